// ===== sfce_top.sv
// Chip-erase sequencer of a serial flash with an AXI4-Lite register window.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "sfce_map.svh"
module sfce_top #(
  parameter int unsigned ADDR_W         = 8,
  parameter int unsigned ERASE_CYCLES   =
    32'((64'(`SFCE_ERASE_TIME_MS) * 64'd1000000) / 64'(`SFCE_ACLK_PERIOD_NS)),
  parameter logic [7:0]  SET_WL_OP      = 8'h06,
  parameter logic [7:0]  STATUS_READ_OP = 8'h05,
  parameter logic [7:0]  CHIP_ERASE_OP  = 8'h62
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_si,
  output logic                   spi_so_o,
  output logic                   spi_so_oe,
  input  wire logic              wp_n,
  output logic                   erase_busy
);
  import sfce_pkg::*;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  // Sector 8 is bit 7; the protect level locks the top of the array first.
  function automatic sfce_byte_t lock_mask(input logic [2:0] level);
    sfce_byte_t m;
    m = 8'h00;
    if (level[2]) begin
      m = 8'hFF;
    end else begin
      unique case (level[1:0])
        2'h0: m = 8'h00;
        2'h1: m = 8'h80;
        2'h2: m = 8'hC0;
        2'h3: m = 8'hF0;
      endcase
    end
    return m;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    logic [7:0] a;
    a = 8'(addr);
    return {a[7:2], 2'h0} == ofs;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return hit(addr, `SFCE_OFS_STATUS) | hit(addr, `SFCE_OFS_PROT) | hit(addr, `SFCE_OFS_SECTORS) |
           hit(addr, `SFCE_OFS_LOCKMASK) | hit(addr, `SFCE_OFS_OPCODE);
  endfunction

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  sfce_state_t state_r;
  logic [31:0] erase_cnt_r;
  sfce_byte_t  erase_lock_r;
  logic        wel_r;
  logic        ignored_r;
  logic [2:0]  bp_r;
  logic        protect_pin_enable_bit_r;
  sfce_byte_t  blank_r;
  sfce_byte_t  last_op_r;
  logic        cs_meta_r;
  logic        cs_sync_r;
  logic        cs_prev_r;
  logic        wp_meta_r;
  logic        wp_sync_r;
  sfce_byte_t  op_meta_r;
  sfce_byte_t  op_sync_r;
  logic        full_meta_r;
  logic        full_sync_r;
  sfce_byte_t  link_op;
  logic        link_full;
  sfce_byte_t  status_byte;
  logic        cs_rise;
  logic        hw_protect;
  logic        busy;
  logic        erase_done;
  logic        start_erase;
  logic        take_wel;
  logic        ignore_evt;
  logic        aw_held_r;
  logic        w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        wr_prot;
  logic        wr_sect;
  logic        wr_stat;

  // ----------------------------------------------------------------------------
  // Link-side logic on the serial clock
  // ----------------------------------------------------------------------------
  sfce_spi_link #(
    .STATUS_READ_OP (STATUS_READ_OP)
  ) u_link (
    .sck      (spi_sck),
    .cs_n     (spi_cs_n),
    .rst_n    (aresetn),
    .si       (spi_si),
    .status_a (status_byte),
    .so_o     (spi_so_o),
    .so_oe    (spi_so_oe),
    .cmd_op   (link_op),
    .cmd_full (link_full)
  );

  // ----------------------------------------------------------------------------
  // Crossings into the system clock
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      wp_meta_r <= 1'b1;
      wp_sync_r <= 1'b1;
    end else begin
      cs_meta_r <= spi_cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      wp_meta_r <= wp_n;
      wp_sync_r <= wp_meta_r;
    end
  end

  // The opcode word is steady from the end of its frame; it is resampled every clock but used only at
  // the synchronised chip select rise, three clocks after the serial clock stopped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_meta_r   <= 8'h00;
      op_sync_r   <= 8'h00;
      full_meta_r <= 1'b0;
      full_sync_r <= 1'b0;
    end else begin
      op_meta_r   <= link_op;
      op_sync_r   <= op_meta_r;
      full_meta_r <= link_full;
      full_sync_r <= full_meta_r;
    end
  end

  assign cs_rise     = cs_sync_r & ~cs_prev_r;
  assign hw_protect  = ~wp_sync_r & protect_pin_enable_bit_r;
  assign busy        = (state_r == SFCE_ERASE);
  assign erase_done  = busy && (erase_cnt_r == 32'h0);
  assign status_byte = {protect_pin_enable_bit_r, 2'h0, bp_r, wel_r, busy};
  assign erase_busy  = busy;

  // ----------------------------------------------------------------------------
  // Command decode at the end of each frame
  // ----------------------------------------------------------------------------
  always_comb begin
    start_erase = 1'b0;
    take_wel    = 1'b0;
    ignore_evt  = 1'b0;
    if (cs_rise) begin
      if (busy) begin
        ignore_evt = op_sync_r != STATUS_READ_OP;
      end else if (!full_sync_r) begin
        ignore_evt = op_sync_r == CHIP_ERASE_OP;
      end else if (op_sync_r == SET_WL_OP) begin
        take_wel = 1'b1;
      end else if (op_sync_r == CHIP_ERASE_OP) begin
        start_erase = wel_r;
        ignore_evt  = ~wel_r;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Erase sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= SFCE_IDLE;
      erase_cnt_r  <= 32'h0;
      erase_lock_r <= 8'h00;
    end else begin
      unique case (state_r)
        SFCE_IDLE: begin
          if (start_erase) begin
            state_r      <= SFCE_ERASE;
            erase_cnt_r  <= ERASE_CYCLES - 32'h1;
            erase_lock_r <= lock_mask(bp_r);
          end
        end
        SFCE_ERASE: begin
          if (erase_done) begin
            state_r <= SFCE_IDLE;
          end else begin
            erase_cnt_r <= erase_cnt_r - 32'h1;
          end
        end
      endcase
    end
  end

  // Write latch: set by its command, dropped when the erase finishes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wel_r <= 1'b0;
    end else if (erase_done) begin
      wel_r <= 1'b0;
    end else if (take_wel) begin
      wel_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_op_r <= 8'h00;
    end else if (cs_rise && full_sync_r) begin
      last_op_r <= op_sync_r;
    end
  end

  // Sticky flag for refused commands; a new refusal beats a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ignored_r <= 1'b0;
    end else if (ignore_evt) begin
      ignored_r <= 1'b1;
    end else if (wr_stat && wstrb_r[0] && wdata_r[`SFCE_ST_IGNORED]) begin
      ignored_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Sector blank map
  // ----------------------------------------------------------------------------
  // Software marks sectors as written with ones; locked sectors keep their state.
  // An erase finishing in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_r <= `SFCE_RST_SECTORS;
    end else if (erase_done) begin
      blank_r <= blank_r | ~erase_lock_r;
    end else if (wr_sect && wstrb_r[0]) begin
      blank_r <= blank_r & ~(wdata_r[7:0] & ~lock_mask(bp_r));
    end
  end

  // ----------------------------------------------------------------------------
  // Protection settings
  // ----------------------------------------------------------------------------
  // Frozen while hardware protection holds or an erase runs, so the lock set
  // captured at the start can drift from what is reported only by a write in the start cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_r   <= `SFCE_RST_BP;
      protect_pin_enable_bit_r <= `SFCE_RST_PROTECT_PIN_ENABLE_BIT;
    end else if (wr_prot && wstrb_r[0] && !hw_protect && !busy) begin
      bp_r   <= wdata_r[`SFCE_PROT_BP_MSB:`SFCE_PROT_BP_LSB];
      protect_pin_enable_bit_r <= wdata_r[`SFCE_PROT_PROTECT_PIN_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------------
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign wr_go         = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_stat       = wr_go & hit(awaddr_r, `SFCE_OFS_STATUS);
  assign wr_prot       = wr_go & hit(awaddr_r, `SFCE_OFS_PROT);
  assign wr_sect       = wr_go & hit(awaddr_r, `SFCE_OFS_SECTORS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SFCE_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(awaddr_r) ? `SFCE_RESP_OKAY : `SFCE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `SFCE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `SFCE_RESP_OKAY : `SFCE_RESP_SLVERR;
      s_axi_rdata  <= 32'h0;
      if (hit(s_axi_araddr, `SFCE_OFS_STATUS)) begin
        s_axi_rdata[`SFCE_ST_BUSY]    <= busy;
        s_axi_rdata[`SFCE_ST_WEL]     <= wel_r;
        s_axi_rdata[`SFCE_ST_HWPROT]  <= hw_protect;
        s_axi_rdata[`SFCE_ST_IGNORED] <= ignored_r;
      end else if (hit(s_axi_araddr, `SFCE_OFS_PROT)) begin
        s_axi_rdata[`SFCE_PROT_BP_MSB:`SFCE_PROT_BP_LSB] <= bp_r;
        s_axi_rdata[`SFCE_PROT_PROTECT_PIN_ENABLE_BIT]                    <= protect_pin_enable_bit_r;
      end else if (hit(s_axi_araddr, `SFCE_OFS_SECTORS)) begin
        s_axi_rdata[7:0] <= blank_r;
      end else if (hit(s_axi_araddr, `SFCE_OFS_LOCKMASK)) begin
        s_axi_rdata[7:0] <= lock_mask(bp_r);
      end else if (hit(s_axi_araddr, `SFCE_OFS_OPCODE)) begin
        s_axi_rdata[7:0] <= last_op_r;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== sfce_map.svh
// Register offsets, field positions, reset values and timing for the chip-erase sequencer.
`ifndef SFCE_MAP_SVH
`define SFCE_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SFCE_OFS_STATUS   8'h00
`define SFCE_OFS_PROT     8'h04
`define SFCE_OFS_SECTORS  8'h08
`define SFCE_OFS_LOCKMASK 8'h0C
`define SFCE_OFS_OPCODE   8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SFCE_ST_BUSY      0
`define SFCE_ST_WEL       1
`define SFCE_ST_HWPROT    2
`define SFCE_ST_IGNORED   3
`define SFCE_PROT_BP_LSB  0
`define SFCE_PROT_BP_MSB  2
`define SFCE_PROT_PROTECT_PIN_ENABLE_BIT    7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SFCE_RST_BP       3'h0
`define SFCE_RST_PROTECT_PIN_ENABLE_BIT     1'h0
`define SFCE_RST_SECTORS  8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SFCE_ERASE_TIME_MS   8000
`define SFCE_ACLK_PERIOD_NS  25

// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define SFCE_RESP_OKAY    2'h0
`define SFCE_RESP_SLVERR  2'h2

`endif

// ===== sfce_pkg.sv
// Types shared by the chip-erase sequencer files.
package sfce_pkg;

  typedef enum logic [0:0] {
    SFCE_IDLE  = 1'b0,
    SFCE_ERASE = 1'b1
  } sfce_state_t;

  typedef logic [7:0] sfce_byte_t;

endpackage

// ===== sfce_spi_link.sv
// Serial-clock side of the flash link: opcode capture and status byte shift-out.
`timescale 1ns/10ps
module sfce_spi_link #(
  parameter logic [7:0] STATUS_READ_OP = 8'h05
) (
  input  wire logic             sck,
  input  wire logic             cs_n,
  input  wire logic             rst_n,
  input  wire logic             si,
  input  wire sfce_pkg::sfce_byte_t status_a,
  output logic                  so_o,
  output logic                  so_oe,
  output sfce_pkg::sfce_byte_t  cmd_op,
  output logic                  cmd_full
);
  import sfce_pkg::*;

  logic [3:0] cnt_r;
  logic [6:0] sh_r;
  sfce_byte_t st_meta_r;
  sfce_byte_t st_r;
  logic       drv_r;

  // ----------------------------------------------------------------------------
  // Bit counter, cleared by the frame's own chip select.
  // ----------------------------------------------------------------------------
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_r <= 4'h0;
      sh_r  <= 7'h00;
    end else begin
      sh_r  <= {sh_r[5:0], si};
      cnt_r <= (cnt_r == 4'hF) ? 4'h8 : cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Opcode word. It is held after the frame so the system clock can read it
  // quasi-statically once chip select has risen. Full means exactly eight bits.
  // ----------------------------------------------------------------------------
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cmd_op   <= 8'h00;
      cmd_full <= 1'b0;
    end else if (cnt_r == 4'h7) begin
      cmd_op   <= {sh_r, si};
      cmd_full <= 1'b1;
    end else begin
      cmd_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Status crossing. The clock only runs in frames, but the opcode gives eight
  // edges, so the two stages settle before the first status bit leaves.
  // ----------------------------------------------------------------------------
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      st_meta_r <= 8'h00;
      st_r      <= 8'h00;
    end else begin
      st_meta_r <= status_a;
      st_r      <= st_meta_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Output on the falling edge; the status byte repeats while the host clocks.
  // ----------------------------------------------------------------------------
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_o  <= 1'b0;
      drv_r <= 1'b0;
    end else if (cnt_r[3] && cmd_op == STATUS_READ_OP) begin
      so_o  <= st_r[3'h7 - cnt_r[2:0]];
      drv_r <= 1'b1;
    end
  end

  assign so_oe = drv_r & ~cs_n;

endmodule

// ===== sfce_asserts.sv
// Port-level checker for the chip-erase sequencer.
`timescale 1ns/10ps
module sfce_asserts #(
  parameter int unsigned ERASE_CYCLES = 50
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        spi_cs_n,
  input wire logic        spi_so_oe,
  input wire logic        erase_busy
);
  logic [31:0] busy_cnt_r;

  // Counts busy cycles so the erase length can be judged when busy falls.
  always_ff @(posedge aclk) begin
    if (!aresetn || !erase_busy) busy_cnt_r <= '0;
    else busy_cnt_r <= busy_cnt_r + 32'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after acceptance");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after acceptance");
  a_bresp_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while response pending");
  a_rresp_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
  a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after being taken");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries nonzero data");
  a_so_quiet: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_so_oe)
    else $error("serial output driven while deselected");
  a_busy_start: assert property ($rose(erase_busy) |-> spi_cs_n && $past(spi_cs_n, 3))
    else $error("erase started while chip select low");
  a_busy_length: assert property ($fell(erase_busy) |-> busy_cnt_r >= ERASE_CYCLES - 1 && busy_cnt_r <= ERASE_CYCLES + 1)
    else $error("erase busy interval wrong length");
endmodule

// ===== sfce_host_model.sv
// Behavioural host controller driving mode 0 frames on the flash link.
`timescale 1ns/10ps
module sfce_host_model (
  output logic  sck,
  output logic  cs_n,
  output logic  si,
  input  wire logic so_o,
  input  wire logic so_oe
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end

  // Sends nbits of op MSB first, then clocks rdb bits back from the device.
  // The clock stands low between frames; the odd start delay keeps it unrelated to aclk.
  task automatic frame(input logic [7:0] op, input int nbits, input int rdb, output logic [7:0] rx);
    rx = 8'h00;
    #7 cs_n = 1'b0;
    for (int i = 0; i < nbits + rdb; i++) begin
      si = (i < nbits) ? op[7-i] : ~si;
      #16 sck = 1'b1;
      if (i >= nbits) rx = {rx[6:0], (so_oe ? so_o : 1'bx)};
      #16 sck = 1'b0;
    end
    #4 cs_n = 1'b1;
    si = ~si;
    #300;
  endtask
endmodule

// ===== spi_flash_chip_erase_tb.sv
// Self-checking bench for the chip-erase sequencer.
`timescale 1ns/10ps
module spi_flash_chip_erase_tb;
  typedef struct packed {logic [7:0] prot; logic [7:0] lock;} sfce_row_t;
  localparam int unsigned EC = 2000;
  logic        aclk, aresetn, wp_n, busy, sck, cs_n, si, so_o, so_oe;
  logic [7:0]  awaddr, araddr, rx;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          n_fail, samples_checked, cycles;
  sfce_row_t   rows [8] = '{'{8'h00, 8'h00}, '{8'h01, 8'h80}, '{8'h02, 8'hC0}, '{8'h03, 8'hF0},
                            '{8'h04, 8'hFF}, '{8'h05, 8'hFF}, '{8'h06, 8'hFF}, '{8'h87, 8'hFF}};

  sfce_top #(.ERASE_CYCLES(EC)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so_o(so_o), .spi_so_oe(so_oe),
    .wp_n(wp_n), .erase_busy(busy));
  sfce_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----
  // Bus and comparison tasks
  // ----
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(d, exp);
  endtask

  task automatic wait_busy(input logic lvl);
    while (busy !== lvl) @(posedge aclk);
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wp_n = 1'b1; aresetn = 1'b0;
    n_fail = 0; samples_checked = 0; cycles = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, {24'h0, rows[i].prot});
      rd_chk(8'h04, {24'h0, rows[i].prot});
      rd_chk(8'h0C, {24'h0, rows[i].lock});
    end
    wr(8'h14, 32'h1);
    check({30'h0, r}, 32'h2);
    rd(8'h14);
    check({30'h0, r}, 32'h2);
    wr(8'h04, 32'h02);
    host_u.frame(8'h62, 8, 0, rx);
    rd_chk(8'h00, 32'h08);
    wr(8'h00, 32'h08);
    rd_chk(8'h00, 32'h00);
    host_u.frame(8'h06, 8, 0, rx);
    host_u.frame(8'h62, 7, 0, rx);
    rd_chk(8'h00, 32'h02);
    host_u.frame(8'h62, 8, 1, rx);
    rd_chk(8'h00, 32'h0A);
    rd_chk(8'h10, 32'h06);
    wr(8'h00, 32'h08);
    host_u.frame(8'h62, 8, 0, rx);
    wait_busy(1'b1);
    rd_chk(8'h00, 32'h03);
    host_u.frame(8'h05, 8, 8, rx);
    check({24'h0, rx}, 32'h0B);
    host_u.frame(8'h62, 8, 0, rx);
    wr(8'h04, 32'h00);
    rd_chk(8'h04, 32'h02);
    wait_busy(1'b0);
    rd_chk(8'h08, 32'h3F);
    rd_chk(8'h00, 32'h08);
    host_u.frame(8'h05, 8, 8, rx);
    check({24'h0, rx}, 32'h08);
    host_u.frame(8'h62, 8, 0, rx);
    check({31'h0, busy}, 32'h0);
    wr(8'h04, 32'h04);
    wr(8'h08, 32'hFF);
    rd_chk(8'h08, 32'h3F);
    wr(8'h04, 32'h02);
    wr(8'h08, 32'h0F);
    rd_chk(8'h08, 32'h30);
    wr(8'h04, 32'h80);
    wp_n <= 1'b0;
    repeat (4) @(posedge aclk);
    rd_chk(8'h00, 32'h0C);
    wr(8'h04, 32'h00);
    rd_chk(8'h04, 32'h80);
    wp_n <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(8'h04, 32'h03);
    rd_chk(8'h04, 32'h03);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h00, 32'h0);
    check({31'h0, so_oe}, 32'h0);
    tally_and_finish();
  end
endmodule

bind sfce_top sfce_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
  .erase_busy(erase_busy));
